/* File: src/fpec_flash_ctrl.v */
`timescale 1ns/1ps
`include "fpec_regs.vh"

// Function
// - Row write timed in RC oscillator ticks
// - Setting start bit 15 begins operation
// - Hardware clears start bit when finished
// - Key register write-only, gates start only
// - Control register selects erase, type, trigger
// - Error flag on bad start or abort
// - Start bit reads zero while idle
module fpec_flash_ctrl #(
	parameter ROW_WRITE_TICKS = `FPEC_ROW_WRITE_TICKS,
	parameter ERASE_TICKS = `FPEC_ERASE_TICKS
) (
	input wire clk,
	input wire rst_n,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output reg [31:0] prdata,
	output wire pslverr,
	input wire rcTick,
	input wire flashFault,
	output reg flashStart,
	output reg flashErase,
	output reg [`FPEC_OPSEL_W-1:0] flashOpSel,
	output wire flashBusy,
	output wire irq
);

	localparam [`FPEC_TICK_W-1:0] ROW_LIMIT = ROW_WRITE_TICKS;
	localparam [`FPEC_TICK_W-1:0] ERASE_LIMIT = ERASE_TICKS;

	// Control register fields
	reg startBit;
	reg enableBit;
	reg errorFlag;
	reg eraseBit;
	reg [`FPEC_OPSEL_W-1:0] opSel;

	// Unlock progress and interrupt state
	reg [1:0] keyState;
	reg [1:0] next_keyState;
	reg [`FPEC_IRQ_W-1:0] irqStatus;
	reg [`FPEC_IRQ_W-1:0] irqMask;

	wire timerDone;
	wire [`FPEC_TICK_W-1:0] timerLimit;

	// APB decode
	wire access = psel && penable;
	wire program_enable_bit = access && pwrite;
	wire rdEn = access && !pwrite;
	wire [`FPEC_ADDR_W-1:0] addr = paddr[`FPEC_ADDR_W-1:0];
	wire hitCtrl = (addr == `FPEC_ADDR_CTRL);
	wire hitKey = (addr == `FPEC_ADDR_KEY);
	wire hitStat = (addr == `FPEC_ADDR_IRQ_STAT);
	wire hitMask = (addr == `FPEC_ADDR_IRQ_MASK);
	wire mapped = hitCtrl || hitKey || hitStat || hitMask;

	// Zero wait states; unmapped addresses answer with an error
	assign pready = 1'b1;
	assign pslverr = access && !mapped;

	wire ctrlWrite = program_enable_bit && hitCtrl;
	wire keyWrite = program_enable_bit && hitKey;
	wire wantStart = ctrlWrite && pwdata[`FPEC_CTRL_START];
	wire newEnable = pwdata[`FPEC_CTRL_ENABLE];

	// Start is honoured only with enable set in the same write and an open key
	wire startOk = wantStart && newEnable && (keyState == `FPEC_KS_OPEN)
		&& !startBit;
	wire startBad = wantStart && !startOk;
	wire faultEnd = startBit && flashFault;

	// Unlock sequence: 0x55 then 0xAA, and the very next write must be the start
	always @* begin
		next_keyState = keyState;
		if (program_enable_bit) begin
			if (keyWrite) begin
				case (keyState)
					`FPEC_KS_IDLE: begin
						if (pwdata[`FPEC_KEY_W-1:0] == `FPEC_KEY_FIRST) begin
							next_keyState = `FPEC_KS_FIRST;
						end
					end
					`FPEC_KS_FIRST: begin
						if (pwdata[`FPEC_KEY_W-1:0] == `FPEC_KEY_SECOND) begin
							next_keyState = `FPEC_KS_OPEN;
						end else if (pwdata[`FPEC_KEY_W-1:0] == `FPEC_KEY_FIRST) begin
							next_keyState = `FPEC_KS_FIRST;
						end else begin
							next_keyState = `FPEC_KS_IDLE;
						end
					end
					`FPEC_KS_OPEN: begin
						// A new key write restarts the sequence
						if (pwdata[`FPEC_KEY_W-1:0] == `FPEC_KEY_FIRST) begin
							next_keyState = `FPEC_KS_FIRST;
						end else begin
							next_keyState = `FPEC_KS_IDLE;
						end
					end
					default: begin
						next_keyState = `FPEC_KS_IDLE;
					end
				endcase
			end else begin
				// Any other write breaks the consecutive requirement
				next_keyState = `FPEC_KS_IDLE;
			end
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			keyState <= `FPEC_KS_IDLE;
		end else begin
			keyState <= next_keyState;
		end
	end

	// Control register
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			startBit <= 1'b0;
			enableBit <= 1'b0;
			errorFlag <= 1'b0;
			eraseBit <= 1'b0;
			opSel <= {`FPEC_OPSEL_W{1'b0}};
		end else begin
			if (startOk) begin
				startBit <= 1'b1;
			end else if (timerDone || faultEnd) begin
				startBit <= 1'b0;
			end
			// Erase and op select are frozen while an operation runs; enable stays writable
			if (ctrlWrite && !startBit) begin
				enableBit <= newEnable;
				eraseBit <= pwdata[`FPEC_CTRL_ERASE];
				opSel <= pwdata[`FPEC_CTRL_OPSEL_HI:`FPEC_CTRL_OPSEL_LO];
			end else if (ctrlWrite) begin
				enableBit <= newEnable;
			end
			// Set wins over a software clear in the same cycle
			if (startBad || faultEnd) begin
				errorFlag <= 1'b1;
			end else if (ctrlWrite && !pwdata[`FPEC_CTRL_ERROR]) begin
				errorFlag <= 1'b0;
			end
		end
	end

	// Selections toward the flash array, latched at start
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flashStart <= 1'b0;
			flashErase <= 1'b0;
			flashOpSel <= {`FPEC_OPSEL_W{1'b0}};
		end else begin
			flashStart <= startOk;
			if (startOk) begin
				flashErase <= pwdata[`FPEC_CTRL_ERASE];
				flashOpSel <= pwdata[`FPEC_CTRL_OPSEL_HI:`FPEC_CTRL_OPSEL_LO];
			end
		end
	end

	assign timerLimit = flashErase ? ERASE_LIMIT : ROW_LIMIT;

	// Timer runs alone once kicked; software plays no part in the duration
	fpec_op_timer uTimer (
		.clk(clk),
		.rst_n(rst_n),
		.start(flashStart),
		.abort(faultEnd),
		.rcTick(rcTick),
		.limit(timerLimit),
		.busy(),
		.done(timerDone)
	);

	assign flashBusy = startBit;

	// Interrupt status: write one to clear, set wins
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irqStatus <= `FPEC_IRQ_RESET;
			irqMask <= `FPEC_IRQ_RESET;
		end else begin
			irqStatus[`FPEC_IRQ_DONE] <= timerDone || (irqStatus[`FPEC_IRQ_DONE]
				&& !(program_enable_bit && hitStat && pwdata[`FPEC_IRQ_DONE]));
			irqStatus[`FPEC_IRQ_ERROR] <= startBad || faultEnd || (irqStatus[`FPEC_IRQ_ERROR]
				&& !(program_enable_bit && hitStat && pwdata[`FPEC_IRQ_ERROR]));
			if (program_enable_bit && hitMask) begin
				irqMask <= pwdata[`FPEC_IRQ_W-1:0];
			end
		end
	end

	assign irq = |(irqStatus & irqMask);

	// Read data registered in the setup cycle, ready for the access cycle
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= 32'h00000000;
			case (addr)
				`FPEC_ADDR_CTRL: begin
					prdata[`FPEC_CTRL_START] <= startBit;
					prdata[`FPEC_CTRL_ENABLE] <= enableBit;
					prdata[`FPEC_CTRL_ERROR] <= errorFlag;
					prdata[`FPEC_CTRL_ERASE] <= eraseBit;
					prdata[`FPEC_CTRL_OPSEL_HI:`FPEC_CTRL_OPSEL_LO] <= opSel;
				end
				`FPEC_ADDR_IRQ_STAT: begin
					prdata[`FPEC_IRQ_W-1:0] <= irqStatus;
				end
				`FPEC_ADDR_IRQ_MASK: begin
					prdata[`FPEC_IRQ_W-1:0] <= irqMask;
				end
				default: begin
					// Key register is write-only and reads zero
					prdata <= 32'h00000000;
				end
			endcase
		end
	end

endmodule // fpec_flash_ctrl

/* File: src/fpec_regs.vh */
`ifndef FPEC_REGS_VH
`define FPEC_REGS_VH

// Register byte addresses
`define FPEC_ADDR_CTRL 12'h000
`define FPEC_ADDR_KEY 12'h004
`define FPEC_ADDR_IRQ_STAT 12'h008
`define FPEC_ADDR_IRQ_MASK 12'h00c
`define FPEC_ADDR_W 12

// flash_operation_control fields
`define FPEC_CTRL_START 15
`define FPEC_CTRL_ENABLE 14
`define FPEC_CTRL_ERROR 13
`define FPEC_CTRL_ERASE 6
`define FPEC_CTRL_OPSEL_HI 3
`define FPEC_CTRL_OPSEL_LO 0
`define FPEC_OPSEL_W 4
`define FPEC_CTRL_RESET 16'h0000

// Unlock key values
`define FPEC_KEY_FIRST 8'h55
`define FPEC_KEY_SECOND 8'haa
`define FPEC_KEY_W 8

// Interrupt status and mask bits
`define FPEC_IRQ_DONE 0
`define FPEC_IRQ_ERROR 1
`define FPEC_IRQ_W 2
`define FPEC_IRQ_RESET 2'h0

// Oscillator ticks per timed operation
`define FPEC_ROW_WRITE_TICKS 11064
`define FPEC_ERASE_TICKS 11064
`define FPEC_RC_FREQ_KHZ 7370
`define FPEC_TICK_W 14

// Unlock progress states
`define FPEC_KS_IDLE 2'h0
`define FPEC_KS_FIRST 2'h1
`define FPEC_KS_OPEN 2'h2

`endif

/* File: src/fpec_op_timer.v */
`timescale 1ns/1ps
`include "fpec_regs.vh"

// Counts internal RC oscillator ticks for one timed operation.
module fpec_op_timer (
	input wire clk,
	input wire rst_n,
	input wire start,
	input wire abort,
	input wire rcTick,
	input wire [`FPEC_TICK_W-1:0] limit,
	output reg busy,
	output reg done
);

	reg [`FPEC_TICK_W-1:0] count;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy <= 1'b0;
			done <= 1'b0;
			count <= {`FPEC_TICK_W{1'b0}};
		end else begin
			done <= 1'b0;
			if (abort) begin
				busy <= 1'b0;
				count <= {`FPEC_TICK_W{1'b0}};
			end else if (start && !busy) begin
				busy <= 1'b1;
				count <= {`FPEC_TICK_W{1'b0}};
			end else if (busy && rcTick) begin
				// Duration tracks the oscillator, not the bus clock
				if (count == limit - 1'b1) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					count <= count + 1'b1;
				end
			end
		end
	end

endmodule // fpec_op_timer

/* File: testbench/fpec_flash_ctrl_monitor.sv */
`timescale 1ns/1ps
`include "fpec_regs.vh"

module fpec_flash_ctrl_monitor (
	input wire clk,
	input wire rst_n,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire rcTick,
	input wire flashFault,
	input wire flashStart,
	input wire flashErase,
	input wire [`FPEC_OPSEL_W-1:0] flashOpSel,
	input wire flashBusy
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire acc = psel && penable;
	wire go = acc && pwrite && paddr[11:0] == `FPEC_ADDR_CTRL && pwdata[15] && pwdata[14];
	a_start_pulse: assert property (flashStart |-> flashBusy && !$past(flashBusy))
		else $error("start pulse without fresh busy");
	a_busy_rise: assert property ($rose(flashBusy) |-> flashStart)
		else $error("busy rose without start");
	a_start_gate: assert property (flashStart |-> $past(go))
		else $error("start without enabled control write");
	a_op_capture: assert property (flashStart |-> flashOpSel == $past(pwdata[3:0]) &&
		flashErase == $past(pwdata[6])) else $error("operation not captured");
	a_op_hold: assert property (flashBusy && !flashStart |-> $stable(flashOpSel))
		else $error("operation changed while busy");
	// Tick edges excluded: completion may land there
	a_self_timed: assert property (flashBusy && !rcTick && !$past(rcTick) && !flashFault
		|=> flashBusy) else $error("busy dropped without cause");
	a_done_cause: assert property ($fell(flashBusy) |-> $past(rcTick, 2) || $past(rcTick) ||
		$past(flashFault)) else $error("busy fell without tick or fault");
	a_key_hidden: assert property (acc && !pwrite && paddr[11:0] == `FPEC_ADDR_KEY
		|-> prdata == 32'h0) else $error("key readable");
	c_erase: cover property (flashStart && flashErase);
	c_done: cover property ($fell(flashBusy) && !$past(flashFault));
	c_fault: cover property (flashBusy && flashFault);
endmodule // fpec_flash_ctrl_monitor

bind fpec_flash_ctrl fpec_flash_ctrl_monitor mon (.*);

/* File: testbench/fpec_flash_ctrl_tb.sv */
`timescale 1ns/1ps
`include "fpec_regs.vh"
`define CHK(n, x, g) begin comparisons++; if ((g) !== (x)) begin failCount++; \
	$display("unexpected %s exp %h got %h", n, x, g); end end

module fpec_flash_ctrl_tb;
	logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, rcTick = 0, flashFault = 0;
	logic tickOn = 0, pready, pslverr, flashStart, flashErase, flashBusy, irq, e;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, q;
	logic [`FPEC_OPSEL_W-1:0] flashOpSel;
	int failCount = 0, comparisons = 0, n;
	// Short timing keeps the run small
	fpec_flash_ctrl #(.ROW_WRITE_TICKS(8), .ERASE_TICKS(8)) dut (
		.clk(clk),
		.rst_n(rst_n),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.pready(pready),
		.prdata(prdata),
		.pslverr(pslverr),
		.rcTick(rcTick),
		.flashFault(flashFault),
		.flashStart(flashStart),
		.flashErase(flashErase),
		.flashOpSel(flashOpSel),
		.flashBusy(flashBusy),
		.irq(irq)
	);
	initial forever #4 clk = ~clk;
	always @(posedge clk) rcTick <= tickOn && !rcTick;
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", comparisons, failCount);
		if (failCount == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= {20'h0, a};
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		for (int i = 0; i <= 20; i++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
			if (i == 20) begin
				failCount++;
				close_out();
			end
		end
		q = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clk);
	endtask
	task automatic unlock;
		xfer(`FPEC_ADDR_KEY, 1, 32'h55);
		xfer(`FPEC_ADDR_KEY, 1, 32'haa);
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1;
		@(posedge clk);
		xfer(`FPEC_ADDR_CTRL, 0, 0);
		`CHK("ctrl reset", 32'h0, q)
		xfer(`FPEC_ADDR_KEY, 0, 0);
		`CHK("key read", 32'h0, q)
		xfer(12'h010, 0, 0);
		`CHK("unmapped", 33'h100000000, {e, q})
		xfer(`FPEC_ADDR_IRQ_MASK, 1, 32'h3);
		xfer(`FPEC_ADDR_CTRL, 1, 32'hc000);
		xfer(`FPEC_ADDR_CTRL, 0, 0);
		`CHK("locked start", 32'h6000, q)
		`CHK("error irq", 1'b1, irq)
		// Status clear doubles as a write that must close the key
		unlock();
		xfer(`FPEC_ADDR_IRQ_STAT, 1, 32'h3);
		xfer(`FPEC_ADDR_CTRL, 1, 32'hc000);
		xfer(`FPEC_ADDR_CTRL, 0, 0);
		`CHK("key closed", 32'h6000, q)
		xfer(`FPEC_ADDR_IRQ_MASK, 1, 32'h0);
		`CHK("masked irq", 1'b0, irq)
		xfer(`FPEC_ADDR_IRQ_MASK, 1, 32'h3);
		xfer(`FPEC_ADDR_IRQ_STAT, 1, 32'h3);
		`CHK("irq clear", 1'b0, irq)
		xfer(`FPEC_ADDR_CTRL, 1, 32'h4000);
		unlock();
		xfer(`FPEC_ADDR_CTRL, 1, 32'hc045);
		xfer(`FPEC_ADDR_CTRL, 0, 0);
		`CHK("start bit", 32'hc045, q)
		`CHK("op select", 5'h15, {flashErase, flashOpSel})
		repeat (3) @(posedge clk);
		`CHK("self timed", 1'b1, flashBusy)
		tickOn <= 1;
		n = 0;
		for (int i = 0; i < 100; i++) begin
			@(negedge clk);
			if (flashBusy !== 1'b1) break;
			n += rcTick;
		end
		`CHK("tick count", 8, n)
		@(posedge clk);
		tickOn <= 0;
		xfer(`FPEC_ADDR_CTRL, 0, 0);
		`CHK("start cleared", 32'h4045, q)
		`CHK("done irq", 1'b1, irq)
		xfer(`FPEC_ADDR_IRQ_STAT, 0, 0);
		`CHK("done status", 32'h1, q)
		unlock();
		xfer(`FPEC_ADDR_CTRL, 1, 32'hc000);
		flashFault <= 1;
		@(posedge clk);
		flashFault <= 0;
		xfer(`FPEC_ADDR_CTRL, 0, 0);
		`CHK("fault abort", 32'h6000, q)
		xfer(`FPEC_ADDR_CTRL, 1, 32'h4000);
		unlock();
		xfer(`FPEC_ADDR_CTRL, 1, 32'hc000);
		unlock();
		xfer(`FPEC_ADDR_CTRL, 1, 32'hc001);
		xfer(`FPEC_ADDR_CTRL, 0, 0);
		`CHK("busy start", 32'he000, q)
		close_out();
	end
endmodule // fpec_flash_ctrl_tb
